// ---- design/wdcm_top.v ----
/*
 * watchdog with service window and clock monitor, behind one
 * memory-mapped service register reached by a plain write/read port.
 * assumes every enabled sys_clk edge is one instruction cycle and that
 * the fault pin's own level is fed back on fault_pin_in.
 */
`timescale 1ns/1ps
`include "wdcm_defines.vh"

module wdcm_top #(
	parameter             CM_GAP_W   = 16,
	parameter [CM_GAP_W-1:0] CM_MAX_GAP = `WDCM_CM_MAX_GAP_CYC
) (
	// clock, reset, enable
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       clk_en,
	// configuration and mode
	input  wire       watchdog_option_en,
	input  wire       wd_inhibit,
	// service register port
	input  wire       svc_wr_en,
	input  wire       svc_rd_en,
	input  wire [7:0] svc_wdata,
	output reg  [7:0] svc_rdata,
	// oscillator under watch
	input  wire       osc_clock_input,
	// fault pin, active low, open drain
	input  wire       fault_pin_in,
	output wire       fault_output_pin_o,
	output reg        fault_output_pin_oe,
	// status
	output reg        cm_fault_o
);

	localparam ST_RUN     = 2'h0;
	localparam ST_PULL    = 2'h1;
	localparam ST_HOLD    = 2'h2;
	localparam ST_RELEASE = 2'h3;

	// fault pin sequencer
	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	// fields fixed by the first valid service
	reg  [1:0]  sel_reg;
	reg         cm_en_reg;
	reg         locked_reg;
	// window timers, each saturating at its limit; hold counter cleared outside the hold
	reg  [16:0] upper_cnt_reg;
	reg  [8:0]  lower_cnt_reg;
	reg  [4:0]  hold_cnt_reg;
	reg  [16:0] upper_limit;
	// decode terms
	wire        cm_fault;
	wire        key_ok;
	wire        fields_ok;
	wire        svc_take;
	wire        svc_valid;
	wire        svc_bad;
	wire        svc_early;
	wire        upper_expire;
	wire        restart;

	// the pin is only ever pulled low; release lets the pull-up win
	assign fault_output_pin_o = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// service decode
	assign key_ok    = (svc_wdata[`WDCM_KEY_MSB:`WDCM_KEY_LSB] == `WDCM_KEY_VALUE);
	assign fields_ok = (svc_wdata[`WDCM_SEL_MSB:`WDCM_SEL_LSB] == sel_reg) &&
	                   (svc_wdata[`WDCM_CM_BIT] == cm_en_reg);
	// services while the fault is out are ignored
	assign svc_take  = watchdog_option_en & svc_wr_en & (state_reg == ST_RUN);
	assign svc_valid = svc_take & key_ok & (fields_ok | ~locked_reg);
	assign svc_bad   = svc_take & ~svc_valid;
	// the first service may land inside the first 256 cycles
	assign svc_early = svc_valid & locked_reg & (lower_cnt_reg < `WDCM_LOWER_LIMIT);

	////////////////////////////////////////////////////////////////////////
	// upper limit per window select
	always @* begin
		case (sel_reg)
			2'h0:    upper_limit = `WDCM_UPPER_8K;
			2'h1:    upper_limit = `WDCM_UPPER_16K;
			2'h2:    upper_limit = `WDCM_UPPER_32K;
			default: upper_limit = `WDCM_UPPER_64K;
		endcase
	end

	assign upper_expire = watchdog_option_en & (state_reg == ST_RUN) &
	                      (upper_cnt_reg >= upper_limit);
	// window restarts once the pin has gone back high
	assign restart = (state_reg == ST_RELEASE) & fault_pin_in;

	////////////////////////////////////////////////////////////////////////
	// clock monitor, enabled by the stored monitor bit while the option is on
	wdcm_clock_monitor #(
		.GAP_W   (CM_GAP_W),
		.MAX_GAP (CM_MAX_GAP)
	) u_cm (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.clk_en          (clk_en),
		.enable          (watchdog_option_en & cm_en_reg),
		.osc_clock_input (osc_clock_input),
		.cm_fault        (cm_fault)
	);

	////////////////////////////////////////////////////////////////////////
	// stored fields; locked after the first key match
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_reg    <= `WDCM_SEL_RESET;
			cm_en_reg  <= `WDCM_CM_RESET;
			locked_reg <= 1'b0;
		end else if (clk_en) begin
			if (svc_valid && !locked_reg) begin
				sel_reg    <= svc_wdata[`WDCM_SEL_MSB:`WDCM_SEL_LSB];
				cm_en_reg  <= svc_wdata[`WDCM_CM_BIT];
				locked_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two independent window timers, one step per instruction cycle
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			upper_cnt_reg <= 17'h00000;
			lower_cnt_reg <= 9'h000;
		end else if (clk_en) begin
			if (svc_valid || restart) begin
				upper_cnt_reg <= 17'h00000;
				lower_cnt_reg <= 9'h000;
			// frozen while halted or idle; the monitor keeps running while halted
			end else if (state_reg == ST_RUN && !wd_inhibit && watchdog_option_en) begin
				if (upper_cnt_reg < upper_limit)
					upper_cnt_reg <= upper_cnt_reg + 17'h00001;
				// lower timer saturates, it only needs to know 256 passed
				if (lower_cnt_reg < `WDCM_LOWER_LIMIT)
					lower_cnt_reg <= lower_cnt_reg + 9'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fault pin sequencing
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (svc_bad || svc_early || upper_expire || cm_fault)
					state_next = ST_PULL;
			end
			ST_PULL: begin
				// hold count starts only once the pin really reads low
				if (!fault_pin_in && !cm_fault)
					state_next = ST_HOLD;
			end
			ST_HOLD: begin
				// a fresh monitor fault restarts the hold from the pull stage
				if (cm_fault)
					state_next = ST_PULL;
				else if (hold_cnt_reg == `WDCM_HOLD_CYCLES - 5'h01)
					state_next = ST_RELEASE;
			end
			ST_RELEASE: begin
				// window restarts only once the pull-up has the pin high again
				if (cm_fault)
					state_next = ST_PULL;
				else if (fault_pin_in)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
	end

	// registered pin enable, so the pin cannot glitch low between states
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg           <= ST_RUN;
			hold_cnt_reg        <= 5'h00;
			fault_output_pin_oe <= 1'b0;
			cm_fault_o          <= 1'b0;
		end else if (clk_en) begin
			state_reg           <= state_next;
			cm_fault_o          <= cm_fault;
			hold_cnt_reg        <= (state_next == ST_HOLD && state_reg == ST_HOLD) ?
			                       hold_cnt_reg + 5'h01 : 5'h00;
			fault_output_pin_oe <= (state_next == ST_PULL) || (state_next == ST_HOLD);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read back; key field always zero so the key cannot leak
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			svc_rdata <= 8'h00;
		end else if (clk_en && svc_rd_en) begin
			svc_rdata <= {sel_reg, 5'h00, cm_en_reg};
		end
	end

endmodule // wdcm_top

// ---- design/wdcm_defines.vh ----
/*
 * constants for the watchdog and clock monitor block: field positions,
 * reset values, window limits and timing counts.
 * assumes it is included by bare name from design files only.
 */
`ifndef WDCM_DEFINES_VH
`define WDCM_DEFINES_VH

// service register field positions
`define WDCM_SEL_MSB        7
`define WDCM_SEL_LSB        6
`define WDCM_KEY_MSB        5
`define WDCM_KEY_LSB        1
`define WDCM_CM_BIT         0

// fixed key pattern 01100
`define WDCM_KEY_VALUE      5'h0C

// reset values: widest window, clock monitor on
`define WDCM_SEL_RESET      2'h3
`define WDCM_CM_RESET       1'h1

// window limits in instruction cycles
`define WDCM_LOWER_LIMIT    9'h100
`define WDCM_UPPER_8K       17'h02000
`define WDCM_UPPER_16K      17'h04000
`define WDCM_UPPER_32K      17'h08000
`define WDCM_UPPER_64K      17'h10000

// fault pin held low this many cycles after the pin reads low
`define WDCM_HOLD_CYCLES    5'h10

// clock monitor: longest gap between oscillator edges (10 kHz floor)
`define WDCM_CLK_PERIOD_PS  4000
`define WDCM_CM_MAX_GAP_NS  100000
// 100 us over a 4 ns clock, sized to the monitor's 16-bit gap counter
`define WDCM_CM_MAX_GAP_CYC 16'h61A8

`endif

// ---- design/wdcm_clock_monitor.v ----
/*
 * clock monitor: flags an absent or too slow oscillator input.
 * assumes osc_clock_input is synchronous to sys_clk and far slower than it.
 */
`timescale 1ns/1ps
`include "wdcm_defines.vh"

module wdcm_clock_monitor #(
	parameter             GAP_W   = 16,
	parameter [GAP_W-1:0] MAX_GAP = `WDCM_CM_MAX_GAP_CYC
) (
	// clock, reset, enable
	input  wire sys_clk,
	input  wire rst_n,
	input  wire clk_en,
	input  wire enable,
	// observed oscillator
	input  wire osc_clock_input,
	// fault level
	output reg  cm_fault
);

	reg             osc_prev_reg;
	reg [GAP_W-1:0] gap_reg;
	wire            osc_rise;

	assign osc_rise = osc_clock_input & ~osc_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// gap counter saturates so a stopped clock keeps the fault standing
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_prev_reg <= 1'b0;
			gap_reg      <= {GAP_W{1'b0}};
			cm_fault     <= 1'b0;
		end else if (clk_en) begin
			osc_prev_reg <= osc_clock_input;
			if (!enable) begin
				gap_reg  <= {GAP_W{1'b0}};
				cm_fault <= 1'b0;
			end else if (osc_rise) begin
				gap_reg <= {GAP_W{1'b0}};
				if (gap_reg < MAX_GAP)
					cm_fault <= 1'b0;
			end else if (gap_reg >= MAX_GAP) begin
				cm_fault <= 1'b1;
			end else begin
				gap_reg <= gap_reg + {{(GAP_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // wdcm_clock_monitor

// ---- test/wdcm_top_sva.sv ----
/*
 * port checker for the watchdog and clock monitor top.
 * assumes it is bound onto wdcm_top and shares its single clock.
 */
`timescale 1ns/1ps
module wdcm_chk #(
	parameter                CM_GAP_W   = 16,
	parameter [CM_GAP_W-1:0] CM_MAX_GAP = 16'h0032
) (
	// clock and reset
	input wire       sys_clk,
	input wire       rst_n,
	// register port
	input wire       watchdog_option_en,
	input wire       svc_wr_en,
	input wire       svc_rd_en,
	input wire [7:0] svc_wdata,
	input wire [7:0] svc_rdata,
	// oscillator and fault pin
	input wire       osc_clock_input,
	input wire       fault_pin_in,
	input wire       fault_output_pin_o,
	input wire       fault_output_pin_oe,
	input wire       cm_fault_o
);
	reg [CM_GAP_W-1:0] gap_reg;
	reg                osc_q_reg;

	// cycles since the last oscillator rise, saturating so it never wraps
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg   <= {CM_GAP_W{1'b0}};
			osc_q_reg <= 1'b0;
		end else begin
			osc_q_reg <= osc_clock_input;
			if (osc_clock_input && !osc_q_reg)
				gap_reg <= {CM_GAP_W{1'b0}};
			else if (gap_reg != {CM_GAP_W{1'b1}})
				gap_reg <= gap_reg + 1'b1;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_pin_low_only: assert property (fault_output_pin_o == 1'b0)
		else $error("fault pin driven high");
	a_key_hidden: assert property (svc_rdata[5:1] == 5'h00)
		else $error("key visible on read");
	a_rdata_hold: assert property (!$past(svc_rd_en) |-> $stable(svc_rdata))
		else $error("read data moved without read");
	a_bad_key: assert property (svc_wr_en && watchdog_option_en && svc_wdata[5:1] != 5'h0C
		&& fault_pin_in && $past(fault_pin_in) && !fault_output_pin_oe |=> fault_output_pin_oe)
		else $error("bad key write without fault");
	a_option_off: assert property (!watchdog_option_en && !fault_output_pin_oe |=> !fault_output_pin_oe)
		else $error("fault with option off");
	a_hold_min: assert property ($fell(fault_pin_in) |-> fault_output_pin_oe[*8] ##8 fault_output_pin_oe)
		else $error("fault pin released early");
	a_cm_raises: assert property (cm_fault_o && watchdog_option_en |-> ##[0:2] fault_output_pin_oe)
		else $error("monitor fault not on pin");
	a_cm_gap: assert property ($rose(cm_fault_o) |-> gap_reg >= CM_MAX_GAP - 2)
		else $error("monitor fault with short gap");
	a_cm_clear: assert property (cm_fault_o && $rose(osc_clock_input) |-> ##[1:24] !cm_fault_o)
		else $error("monitor fault stuck");
endmodule // wdcm_chk

bind wdcm_top wdcm_chk #(.CM_GAP_W(CM_GAP_W), .CM_MAX_GAP(CM_MAX_GAP)) u_chk (.sys_clk, .rst_n,
	.watchdog_option_en, .svc_wr_en, .svc_rd_en, .svc_wdata, .svc_rdata, .osc_clock_input,
	.fault_pin_in, .fault_output_pin_o, .fault_output_pin_oe, .cm_fault_o);

// ---- test/testbench.sv ----
/*
 * self-checking bench for wdcm_top.
 * assumes a pull-up on the fault pin and a short monitor gap of 50 cycles.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module testbench;
	reg        sys_clk, rst_n, opt_en, wr_en, rd_en, osc_run, ce, inh;
	reg  [7:0] wdata, d;
	reg  [3:0] osc_cnt;
	wire [7:0] rdata;
	wire       pin_o, pin_oe, cm_f, pin;
	int        err_count, n_checks, n, s;

	assign pin = pin_oe ? pin_o : 1'b1; // pull-up when released
	wdcm_top #(.CM_MAX_GAP(16'h0032)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce),
		.watchdog_option_en(opt_en), .wd_inhibit(inh), .svc_wr_en(wr_en), .svc_rd_en(rd_en),
		.svc_wdata(wdata), .svc_rdata(rdata), .osc_clock_input(osc_cnt[3]), .fault_pin_in(pin),
		.fault_output_pin_o(pin_o), .fault_output_pin_oe(pin_oe), .cm_fault_o(cm_f));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// oscillator of 16 cycles, stopped to provoke the monitor
	always @(posedge sys_clk) if (osc_run) osc_cnt <= osc_cnt + 4'h1;

	////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task idle(input int c); repeat (c) @(posedge sys_clk); endtask
	task do_reset; rst_n <= 1'b0; idle(2); rst_n <= 1'b1; endtask
	task wr(input [7:0] v); wdata <= v; wr_en <= 1'b1; idle(1); wr_en <= 1'b0; endtask
	// expected read back: window select, key shown as zeros, monitor bit
	function automatic [7:0] exp_rd(input [1:0] sel, input cm);
		exp_rd = {sel, 5'h00, cm};
	endfunction
	// upper limit in cycles for a window code: 8k doubled per step, k being 1024
	function automatic int upper_cycles(input [1:0] sel);
		upper_cycles = 1024 * (8 << sel);
	endfunction
	task rd(input [7:0] e);
		rd_en <= 1'b1;
		idle(1);
		rd_en <= 1'b0;
		#1 `CHK(rdata, e)
		idle(1);
	endtask
	// oe is looked at on falling edges, away from its own update
	task fault(input logic e);
		n = 0;
		repeat (3) @(negedge sys_clk);
		`CHK(pin_oe, e)
		while (pin_oe && n < 80) begin @(negedge sys_clk); n++; end
		if (e) `CHK(n > 12, 1'b1)
		idle(4);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(10277));
		{rst_n, wr_en, rd_en, wdata, osc_cnt} = '0;
		{opt_en, osc_run, ce, inh} = 4'hE;
		for (s = 0; s < 4; s++) begin
			do_reset;
			rd(exp_rd(2'h3, 1'b1));
			wr({s[1:0], 5'h0C, s[0]});
			fault(1'b0);
			rd(exp_rd(s[1:0], s[0]));
			if (!s[0]) begin
				osc_run <= 1'b0;
				idle(120);
				@(negedge sys_clk) `CHK({cm_f, pin_oe}, 2'h0)
				idle(1);
				osc_run <= 1'b1;
			end
			$display("test select %0d done", s);
		end
		wr(8'hD9); fault(1'b1);
		idle(300); wr(8'hD9); fault(1'b0);
		idle(300); wr(8'h59); fault(1'b1);
		idle(300); wr(8'hD8); fault(1'b1);
		repeat (4) begin
			idle(300);
			d = 8'($urandom);
			if (d[5:1] == 5'h0C) d[2] = 1'b0;
			wr(d); fault(1'b1);
		end
		$display("test services done");
		// expiry for the two shortest windows, timers paused by halt and by the clock enable first
		for (s = 0; s < 2; s++) begin
			do_reset;
			wr({s[1:0], 5'h0C, 1'b1});
			inh <= 1'b1;
			idle(100);
			inh <= 1'b0;
			ce <= 1'b0;
			idle(20);
			ce <= 1'b1;
			n = 0;
			while (!pin_oe && n < 20000) begin @(negedge sys_clk); n++; end
			`CHK(n > upper_cycles(s[1:0]) - 5 && n < upper_cycles(s[1:0]) + 5, 1'b1)
			idle(40);
		end
		$display("test expiry done");
		osc_run <= 1'b0; idle(80);
		@(negedge sys_clk) `CHK({cm_f, pin_oe}, 2'h3)
		idle(1); osc_run <= 1'b1; idle(60);
		@(negedge sys_clk) `CHK(cm_f, 1'b0)
		idle(1); opt_en <= 1'b0; do_reset; wr(8'h00); fault(1'b0);
		$display("test monitor and option done");
		summarize;
	end
	// watchdog, far beyond the roughly 30k cycles the tests need
	initial begin
		idle(60000);
		err_count++;
		summarize;
	end
endmodule // testbench
